// >>> design/tws_pkg.sv
package tws_pkg;

  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] ADDR_DATA = 32'h0000_0008;
  localparam logic [31:0] ADDR_OWN = 32'h0000_000C;
  localparam logic [31:0] ADDR_IRQ_STAT = 32'h0000_0010;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h0000_0014;

  localparam int CTRL_SERVICE = 7;
  localparam int CTRL_ACK = 6;
  localparam int CTRL_START = 5;
  localparam int CTRL_STOP = 4;
  localparam int CTRL_ENABLE = 2;

  localparam int OWN_GCE = 0;

  localparam int IRQ_SERVICE = 0;
  localparam int IRQ_START_SENT = 1;
  localparam int IRQ_W = 2;

  localparam logic [7:0] ST_IDLE = 8'hF8;
  localparam logic [7:0] ST_OWN_W = 8'h60;
  localparam logic [7:0] ST_GC = 8'h70;
  localparam logic [7:0] ST_GC_LOST = 8'h78;
  localparam logic [7:0] ST_OWN_ACK = 8'h80;
  localparam logic [7:0] ST_OWN_NACK = 8'h88;
  localparam logic [7:0] ST_GC_ACK = 8'h90;
  localparam logic [7:0] ST_GC_NACK = 8'h98;
  localparam logic [7:0] ST_STOP = 8'hA0;
  localparam logic [7:0] ST_OWN_R = 8'hA8;
  localparam logic [7:0] ST_TX_ACK = 8'hB8;
  localparam logic [7:0] ST_TX_NACK = 8'hC0;

  localparam logic [6:0] BROADCAST_ADDRESS = 7'h00;
  localparam logic [6:0] OWN_ADDR_RESET = 7'h00;

  // bus-free hold before a queued start, and start hold / low time
  localparam int T_BUF_NS = 4700;
  localparam int CLK_NS = 40;
  localparam int BUF_CYC = (T_BUF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] BUF_CYC_W = 8'(BUF_CYC);

  typedef struct packed {
    logic sda;
    logic scl;
  } tws_line_t;

  typedef struct packed {
    logic ack_enable;
    logic start_request;
    logic stop_request;
    logic enable;
  } tws_ctrl_t;

endpackage : tws_pkg

// >>> design/tws_slave_rx.sv
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
// Function
// - gc data acked gives 0x90, next byte acked per ack_enable
// - gc data nacked gives 0x98, then not-addressed slave after service
// - stop or repeated start while addressed as receiver gives 0xA0, then not-addressed
// - exit with ack_enable 0 ignores own address and broadcast address
// - exit with ack_enable 1 sees own address, broadcast only if enabled
// - start_request on exit queues a start once the bus is free
// - broadcast then data gives 0x90 per acked byte, stop gives 0xA0
// - unacked final broadcast byte gives 0x98 not 0x90
// - slave transmitter sends data bytes to the addressing master
// - arbitration lost then broadcast-addressed gives 0x78, stays receiver
// - broadcast address acked gives 0x70, then receives data
// - own-address data nacked gives 0x88, then not-addressed with same exits
module tws_slave_rx (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic arb_lost,
  output logic irq
);

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_BITS,
    PH_ACK,
    PH_WAIT,
    PH_START
  } tws_phase_t;

  localparam int IRQ_W_L = tws_pkg::IRQ_W;

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    tws_pkg::tws_line_t prev;
    tws_pkg::tws_ctrl_t ctrl;
    logic service;
    logic gce;
    logic [6:0] own_addr;
    logic [7:0] status;
    logic [7:0] shift;
    logic [7:0] data;
    logic [3:0] nbit;
    tws_phase_t ph;
    logic addressed;
    logic gc_mode;
    logic tx_mode;
    logic addr_byte;
    logic ack_now;
    logic pend_exit;
    logic pend_start;
    logic busy;
    logic [7:0] buf_cnt;
    logic sda_drive;
    logic [IRQ_W_L-1:0] ist;
    logic [IRQ_W_L-1:0] imask;
    logic [31:0] rdata;
    logic [31:0] waddr;
    logic wpend;
  } tws_state_t;

  tws_state_t q, d;
  logic scl_rise, scl_fall, start_c, stop_c;

  function automatic logic [31:0] rd_mux(input tws_state_t s, input logic [31:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      tws_pkg::ADDR_CTRL: begin
        r[tws_pkg::CTRL_SERVICE] = s.service;
        r[tws_pkg::CTRL_ACK] = s.ctrl.ack_enable;
        r[tws_pkg::CTRL_START] = s.ctrl.start_request;
        r[tws_pkg::CTRL_STOP] = s.ctrl.stop_request;
        r[tws_pkg::CTRL_ENABLE] = s.ctrl.enable;
      end
      tws_pkg::ADDR_STATUS: r = {24'h00_0000, s.status[7:3], 3'b000};
      tws_pkg::ADDR_DATA: r = {24'h00_0000, s.data};
      tws_pkg::ADDR_OWN: r = {24'h00_0000, s.own_addr, s.gce};
      tws_pkg::ADDR_IRQ_STAT: r = {30'h0000_0000, s.ist};
      tws_pkg::ADDR_IRQ_MASK: r = {30'h0000_0000, s.imask};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : rd_mux

  // broadcast decode is shared by recognition, mode and status
  function automatic logic is_broadcast(input logic [7:0] b);
    return b[7:1] == tws_pkg::BROADCAST_ADDRESS;
  endfunction : is_broadcast

  // status after an acknowledged address byte
  function automatic logic [7:0] addr_status(input logic [7:0] b, input logic lost);
    logic [7:0] st;
    if (b[0]) begin
      st = tws_pkg::ST_OWN_R;
    end else if (is_broadcast(b)) begin
      st = lost ? tws_pkg::ST_GC_LOST : tws_pkg::ST_GC;
    end else begin
      st = tws_pkg::ST_OWN_W;
    end
    return st;
  endfunction : addr_status

  // status after a received data byte, by addressing mode and ack
  function automatic logic [7:0] rx_status(input logic gc, input logic acked);
    logic [7:0] st;
    if (gc) begin
      st = acked ? tws_pkg::ST_GC_ACK : tws_pkg::ST_GC_NACK;
    end else begin
      st = acked ? tws_pkg::ST_OWN_ACK : tws_pkg::ST_OWN_NACK;
    end
    return st;
  endfunction : rx_status

  // one next-state process; bus writes first so line events below win
  always_comb begin
    d = q;
    d.scl_s = {q.scl_s[0], scl_i};
    d.sda_s = {q.sda_s[0], sda_i};
    d.prev = '{sda: q.sda_s[1], scl: q.scl_s[1]};
    scl_rise = q.scl_s[1] & ~q.prev.scl;
    scl_fall = ~q.scl_s[1] & q.prev.scl;
    start_c = q.scl_s[1] & q.prev.scl & q.prev.sda & ~q.sda_s[1];
    stop_c = q.scl_s[1] & q.prev.scl & ~q.prev.sda & q.sda_s[1];
    // bus write data phase
    if (q.wpend) begin
      d.wpend = 1'b0;
      unique case (q.waddr)
        tws_pkg::ADDR_CTRL: begin
          d.ctrl.ack_enable = hwdata[tws_pkg::CTRL_ACK];
          d.ctrl.start_request = hwdata[tws_pkg::CTRL_START];
          d.ctrl.stop_request = hwdata[tws_pkg::CTRL_STOP];
          d.ctrl.enable = hwdata[tws_pkg::CTRL_ENABLE];
          if (hwdata[tws_pkg::CTRL_SERVICE] && q.service) begin
            d.service = 1'b0;
            if (q.pend_exit) begin
              d.pend_exit = 1'b0;
              d.addressed = 1'b0;
              d.gc_mode = 1'b0;
              d.tx_mode = 1'b0;
              d.ph = PH_IDLE;
              d.pend_start = hwdata[tws_pkg::CTRL_START];
            end
          end
        end
        tws_pkg::ADDR_DATA: d.data = hwdata[7:0];
        tws_pkg::ADDR_OWN: begin
          d.own_addr = hwdata[7:1];
          d.gce = hwdata[tws_pkg::OWN_GCE];
        end
        tws_pkg::ADDR_IRQ_STAT: d.ist = q.ist & ~hwdata[IRQ_W_L-1:0];
        tws_pkg::ADDR_IRQ_MASK: d.imask = hwdata[IRQ_W_L-1:0];
        default: d.wpend = 1'b0;
      endcase
    end
    if (hsel && hready && htrans[1]) begin
      d.wpend = hwrite;
      d.waddr = {haddr[31:2], 2'b00};
      d.rdata = rd_mux(q, {haddr[31:2], 2'b00});
    end
    if (start_c) d.busy = 1'b1;
    if (stop_c) d.busy = 1'b0;
    if (q.ctrl.enable) begin
      if ((start_c || stop_c) && q.addressed && !q.tx_mode && !q.service) begin
        d.status = tws_pkg::ST_STOP;
        d.service = 1'b1;
        d.pend_exit = 1'b1;
        d.ph = PH_WAIT;
      end else if (start_c && q.ph != PH_START) begin
        // our own queued start must not restart address reception
        d.ph = PH_BITS;
        d.addr_byte = 1'b1;
        // a stale read direction would drive sda during the next address
        d.tx_mode = 1'b0;
        d.nbit = 4'h0;
        d.addressed = 1'b0;
      end else if (stop_c && !q.addressed) begin
        d.ph = PH_IDLE;
      end
      unique case (q.ph)
        PH_BITS: begin
          if (scl_rise && !q.tx_mode) begin
            d.shift = {q.shift[6:0], q.sda_s[1]};
            d.nbit = q.nbit + 4'h1;
          end
          if (scl_fall && q.tx_mode) begin
            d.sda_drive = ~q.shift[7];
            d.shift = {q.shift[6:0], 1'b1};
            d.nbit = q.nbit + 4'h1;
          end
          if (scl_fall && q.nbit == 4'h8) begin
            d.ph = PH_ACK;
            d.sda_drive = 1'b0;
            if (q.addr_byte) begin
              // recognition only while ack_enable is set
              d.ack_now = q.ctrl.ack_enable &&
                ((q.shift[7:1] == q.own_addr) ||
                 (is_broadcast(q.shift) && q.gce && !q.shift[0]));
              d.sda_drive = d.ack_now;
            end else if (!q.tx_mode) begin
              d.ack_now = q.ack_now;
              d.sda_drive = q.ack_now;
            end
          end
        end
        PH_ACK: begin
          if (scl_fall) begin
            d.sda_drive = 1'b0;
            d.ph = PH_WAIT;
            d.service = 1'b1;
            if (q.tx_mode) begin
              d.status = q.sda_s[1] ? tws_pkg::ST_TX_NACK : tws_pkg::ST_TX_ACK;
              d.pend_exit = q.sda_s[1];
            end else if (q.addr_byte) begin
              d.addr_byte = 1'b0;
              d.addressed = q.ack_now;
              d.gc_mode = is_broadcast(q.shift);
              d.tx_mode = q.shift[0];
              if (!q.ack_now) begin
                d.service = 1'b0;
                d.ph = PH_IDLE;
              end else begin
                d.status = addr_status(q.shift, arb_lost);
              end
            end else begin
              d.data = q.shift;
              d.status = rx_status(q.gc_mode, q.ack_now);
              d.pend_exit = !q.ack_now;
            end
          end
        end
        PH_WAIT: begin
          if (!q.service && !q.wpend) begin
            d.ph = q.addressed ? PH_BITS : PH_IDLE;
            d.nbit = 4'h0;
            d.ack_now = q.ctrl.ack_enable;
            // bit 7 goes out one cycle after scl_oe has dropped and the stretch is released
            if (q.tx_mode) begin
              d.sda_drive = ~q.data[7];
              d.shift = {q.data[6:0], 1'b1};
              d.nbit = 4'h1;
            end
          end
        end
        PH_START: begin
          if (q.buf_cnt == tws_pkg::BUF_CYC_W) begin
            // releasing sda here shows the bus a stop, which frees it again
            d.ph = PH_IDLE;
            d.pend_start = 1'b0;
            d.sda_drive = 1'b0;
            d.ist[tws_pkg::IRQ_START_SENT] = 1'b1;
          end else begin
            d.sda_drive = 1'b1;
            d.buf_cnt = q.buf_cnt + 8'h01;
          end
        end
        default: begin
          // the bus must stay free for the whole count before our start
          if (q.pend_start && !q.busy) begin
            if (q.buf_cnt == tws_pkg::BUF_CYC_W) begin
              d.ph = PH_START;
              d.buf_cnt = 8'h00;
            end else begin
              d.buf_cnt = q.buf_cnt + 8'h01;
            end
          end else begin
            d.buf_cnt = 8'h00;
          end
        end
      endcase
    end
    // set wins over a same-cycle clear
    if (d.service && !q.service) d.ist[tws_pkg::IRQ_SERVICE] = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q.scl_s <= 2'b11;
      q.sda_s <= 2'b11;
      q.prev <= 2'b11;
      q.ctrl <= '0;
      q.service <= 1'b0;
      q.gce <= 1'b0;
      q.own_addr <= tws_pkg::OWN_ADDR_RESET;
      q.status <= tws_pkg::ST_IDLE;
      q.shift <= 8'h00;
      q.data <= 8'h00;
      q.nbit <= 4'h0;
      q.ph <= PH_IDLE;
      q.addressed <= 1'b0;
      q.gc_mode <= 1'b0;
      q.tx_mode <= 1'b0;
      q.addr_byte <= 1'b0;
      q.ack_now <= 1'b0;
      q.pend_exit <= 1'b0;
      q.pend_start <= 1'b0;
      q.busy <= 1'b0;
      q.buf_cnt <= 8'h00;
      q.sda_drive <= 1'b0;
      q.ist <= '0;
      q.imask <= '0;
      q.rdata <= 32'h0000_0000;
      q.waddr <= 32'h0000_0000;
      q.wpend <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // zero wait states: every register answers in the data phase
  assign hrdata = q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // open drain: the pins only ever pull low, the pull-ups make the highs
  assign scl_o = 1'b0;
  // stretch only while a status waits for software
  assign scl_oe = q.service && q.ph == PH_WAIT;
  assign sda_o = 1'b0;
  assign sda_oe = q.sda_drive;
  assign irq = |(q.ist & q.imask);

endmodule : tws_slave_rx
`default_nettype wire

// >>> testbench/tws_slave_rx_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module tws_slave_rx_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic irq
);
  logic dp_q, wr_q, svc;
  logic [31:0] a_q;
  logic [1:0] svc_q;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // data phase tracker, so write data meets its address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_q <= 1'b0;
      svc_q <= 2'h0;
    end else begin
      dp_q <= hsel && hready && htrans[1];
      svc_q <= {svc_q[0], svc};
    end
  end
  always_ff @(posedge hclk) begin
    wr_q <= hwrite;
    a_q <= haddr;
  end
  assign svc = dp_q && wr_q && a_q == tws_pkg::ADDR_CTRL && hwdata[tws_pkg::CTRL_SERVICE];
  sequence rd_at(a);
    dp_q && !wr_q && a_q == a;
  endsequence
  sequence mask_off;
    dp_q && wr_q && a_q == tws_pkg::ADDR_IRQ_MASK && hwdata == 32'h0;
  endsequence
  a_resp_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  a_open_drain: assert property (!scl_o && !sda_o) else $error("pin driven high");
  a_reset_quiet: assert property ($rose(hresetn) |-> !irq && !scl_oe && !sda_oe)
    else $error("outputs busy after reset");
  a_service_frees: assert property (svc |-> ##[1:4] !scl_oe)
    else $error("clock still held after answer");
  a_stretch_hold: assert property (scl_oe && !svc && svc_q == 2'h0 |=> scl_oe)
    else $error("clock let go without answer");
  a_status_low: assert property (rd_at(tws_pkg::ADDR_STATUS) |-> hrdata[2:0] == 3'h0)
    else $error("status low bits not zero");
  a_unmapped_zero: assert property (rd_at(32'h0000_0020) |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_mask_quiet: assert property (mask_off |-> ##[1:2] !irq) else $error("masked irq high");
endmodule : tws_slave_rx_asserts
bind tws_slave_rx tws_slave_rx_asserts chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_o(scl_o), .scl_oe(scl_oe),
  .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
`default_nettype wire

// >>> testbench/tws_bus_master.sv
`timescale 1ns/100ps
`default_nettype none
module tws_bus_master (
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // data moves only 80 ns after a fall, so no false start or stop is seen
  task automatic clk_bit(output logic s);
    #80;
    scl_low = 1'b0;
    wait (scl);
    #80;
    s = sda;
    #80;
    scl_low = 1'b1;
    #80;
  endtask : clk_bit
  task automatic start_c();
    sda_low = 1'b1;
    #160;
    scl_low = 1'b1;
    #80;
  endtask : start_c
  task automatic stop_c();
    logic s;
    sda_low = 1'b1;
    #80;
    scl_low = 1'b0;
    wait (scl);
    #160;
    sda_low = 1'b0;
    #160;
  endtask : stop_c
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_low = !b[i];
      clk_bit(s);
    end
    sda_low = 1'b0;
    clk_bit(s);
    ack = !s;
  endtask : put_byte
  task automatic get_byte(input logic ack, output logic [7:0] b);
    logic s;
    sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(s);
      b[i] = s;
    end
    sda_low = ack;
    clk_bit(s);
    sda_low = 1'b0;
  endtask : get_byte
endmodule : tws_bus_master
`default_nettype wire

// >>> testbench/tws_slave_rx_test.sv
`timescale 1ns/100ps
`default_nettype none
module tws_slave_rx_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic arb_lost = 1'b0;
  logic [31:0] hrdata, r;
  logic hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, irq, m_scl, m_sda, ack;
  logic [7:0] seed = 8'h37;
  logic [7:0] b;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  // pulled-up open-drain wires
  wire logic scl = !(scl_oe || m_scl);
  wire logic sda = !(sda_oe || m_sda);
  always #20 hclk = !hclk;
  tws_slave_rx uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .arb_lost(arb_lost),
    .irq(irq));
  tws_bus_master m (.scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask : check
  task automatic print_verdict();
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic wait_irq();
    for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge hclk);
    check(irq, 32'h1);
  endtask : wait_irq
  // status first, then clear the event, then answer
  task automatic serve(input logic [7:0] st, input logic [7:0] ctl);
    wait_irq();
    ahb(1'b0, tws_pkg::ADDR_STATUS, 32'h0);
    check(r & 32'hF8, st);
    ahb(1'b1, tws_pkg::ADDR_IRQ_STAT, 32'h1);
    ahb(1'b1, tws_pkg::ADDR_CTRL, {24'h0, ctl});
  endtask : serve
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, tws_pkg::ADDR_STATUS, 32'h0);
    check(r, 32'hF8);
    ahb(1'b0, 32'h0000_0020, 32'h0);
    check(r, 32'h0);
    ahb(1'b1, tws_pkg::ADDR_OWN, 32'h55);
    ahb(1'b1, tws_pkg::ADDR_IRQ_MASK, 32'h3);
    ahb(1'b1, tws_pkg::ADDR_CTRL, 32'h44);
    m.start_c();
    m.put_byte(8'h00, ack);
    check(ack, 32'h1);
    wait_irq();
    ahb(1'b1, tws_pkg::ADDR_IRQ_MASK, 32'h0);
    @(posedge hclk);
    check(irq, 32'h0);
    ahb(1'b1, tws_pkg::ADDR_IRQ_MASK, 32'h3);
    serve(tws_pkg::ST_GC, 8'hC4);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      m.put_byte(seed, ack);
      check(ack, 32'h1);
      serve(tws_pkg::ST_GC_ACK, (i == 2) ? 8'h84 : 8'hC4);
      ahb(1'b0, tws_pkg::ADDR_DATA, 32'h0);
      check(r, {24'h0, seed});
    end
    m.put_byte(lfsr(seed), ack);
    check(ack, 32'h0);
    serve(tws_pkg::ST_GC_NACK, 8'hC4);
    m.stop_c();
    m.start_c();
    m.put_byte(8'h54, ack);
    check(ack, 32'h1);
    serve(tws_pkg::ST_OWN_W, 8'hC4);
    m.stop_c();
    serve(tws_pkg::ST_STOP, 8'h84);
    m.start_c();
    m.put_byte(8'h00, ack);
    check(ack, 32'h0);
    check(irq, 32'h0);
    m.stop_c();
    m.start_c();
    m.put_byte(8'h54, ack);
    check(ack, 32'h0);
    m.stop_c();
    ahb(1'b1, tws_pkg::ADDR_CTRL, 32'h44);
    ahb(1'b1, tws_pkg::ADDR_OWN, 32'h54);
    m.start_c();
    m.put_byte(8'h00, ack);
    check(ack, 32'h0);
    m.stop_c();
    ahb(1'b1, tws_pkg::ADDR_OWN, 32'h55);
    m.start_c();
    m.put_byte(8'h54, ack);
    serve(tws_pkg::ST_OWN_W, 8'h84);
    seed = lfsr(seed);
    m.put_byte(seed, ack);
    check(ack, 32'h0);
    serve(tws_pkg::ST_OWN_NACK, 8'hC4);
    ahb(1'b0, tws_pkg::ADDR_DATA, 32'h0);
    check(r, {24'h0, seed});
    m.stop_c();
    m.start_c();
    m.put_byte(8'h55, ack);
    check(ack, 32'h1);
    seed = lfsr(seed);
    ahb(1'b1, tws_pkg::ADDR_DATA, {24'h0, seed});
    serve(tws_pkg::ST_OWN_R, 8'h84);
    m.get_byte(1'b0, b);
    check(b, {24'h0, seed});
    serve(tws_pkg::ST_TX_NACK, 8'hC4);
    m.stop_c();
    arb_lost <= 1'b1;
    m.start_c();
    m.put_byte(8'h00, ack);
    check(ack, 32'h1);
    serve(tws_pkg::ST_GC_LOST, 8'h84);
    arb_lost <= 1'b0;
    m.put_byte(seed, ack);
    check(ack, 32'h0);
    serve(tws_pkg::ST_GC_NACK, 8'hA4);
    m.stop_c();
    wait_irq();
    ahb(1'b0, tws_pkg::ADDR_IRQ_STAT, 32'h0);
    check(r & 32'h2, 32'h2);
    print_verdict();
  end
endmodule : tws_slave_rx_test
`default_nettype wire
